//--- rtl/smh_pkg.sv
// Purpose: Shared constants for the five-signal access handshake slave.
// Assumes: The core clock runs at 50 MHz.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package smh_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 20;
    localparam int REQ_TIME_NS    = 1000;
    localparam int REQ_CYC        = (REQ_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int PREP_TIME_NS   = 200;
    localparam int PREP_CYC       = (PREP_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int SYNC_NS        = 3 * MCLK_PERIOD_NS;
    localparam int READY_TIME_US  = 2;
    localparam int RESUME_TIME_US = 10;
    localparam int CNT_W          = 8;
    localparam int TIME_W         = 16;

    // ------------------------------------------------------------------
    // Reset values and last bit index
    // ------------------------------------------------------------------
    localparam logic [7:0] TX_RESET   = 8'h00;
    localparam logic [7:0] RX_RESET   = 8'h00;
    localparam logic [2:0] IDX_RESET  = 3'h0;
    localparam logic [2:0] IDX_LAST   = 3'h7;

    // ------------------------------------------------------------------
    // Handshake states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OFF  = 6'h01,
        ST_IDLE = 6'h02,
        ST_REQ  = 6'h04,
        ST_PREP = 6'h08,
        ST_WAIT = 6'h10,
        ST_SEL  = 6'h20
    } smh_state_t;

endpackage

//--- rtl/smh_link_if.sv
// Purpose: Carries received bytes and the bit position from the serial side.
// Assumes: rx_byte is stable whenever rx_toggle has changed.
// Notes:   The core side synchronises only rx_toggle; rx_byte and bit_idx are read directly.
`timescale 1ns/1ns
interface smh_link_if;
    logic [7:0] rx_byte;
    logic       rx_toggle;
    logic [2:0] bit_idx;

    modport link (output rx_byte, output rx_toggle, output bit_idx);
    modport core (input rx_byte, input rx_toggle, input bit_idx);
endinterface

//--- rtl/smh_link.sv
// Purpose: Serial clock side: shifts MOSI in, mode 0, MSB first.
// Assumes: The serial clock only runs while chip select is low.
// Notes:   The bit position is cleared by chip select going high.
`timescale 1ns/1ns
module smh_link (
    input  wire logic i_sclk,
    input  wire logic i_reset_n,
    input  wire logic i_cs_n,
    input  wire logic i_mosi,
    smh_link_if.link  lnk
);
    import smh_pkg::*;

    logic       frame_rst_n;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [2:0] next_idx;
    logic [7:0] next_rx;
    logic       next_tog;

    // ------------------------------------------------------------------
    // Frame state, ended by chip select itself
    // ------------------------------------------------------------------
    assign frame_rst_n = i_reset_n & ~i_cs_n;

    always_comb begin
        next_shift = {shift[6:0], i_mosi};
        next_idx   = lnk.bit_idx + 3'h1;
        next_rx    = lnk.rx_byte;
        next_tog   = lnk.rx_toggle;
        if (lnk.bit_idx == IDX_LAST) begin
            next_rx  = next_shift;
            next_tog = ~lnk.rx_toggle;
        end
    end

    always_ff @(posedge i_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            shift       <= RX_RESET;
            lnk.bit_idx <= IDX_RESET;
        end else begin
            shift       <= next_shift;
            lnk.bit_idx <= next_idx;
        end
    end

    // The event toggle survives the frame so no edge is faked at its end.
    always_ff @(posedge i_sclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lnk.rx_byte   <= RX_RESET;
            lnk.rx_toggle <= 1'b0;
        end else begin
            lnk.rx_byte   <= next_rx;
            lnk.rx_toggle <= next_tog;
        end
    end

endmodule

//--- rtl/smh_slave.sv
// Purpose: Slave end of the five-signal access handshake with a byte datapath.
// Assumes: i_mclk at 50 MHz; the serial clock comes from the master.
// Notes:   MISO is a mux of two quasi-static flops, see the hand-over.
`timescale 1ns/1ns
module smh_slave #(
    parameter int PREP_CYCLES = smh_pkg::PREP_CYC,
    parameter int READY_US    = smh_pkg::READY_TIME_US,
    parameter int RESUME_US   = smh_pkg::RESUME_TIME_US
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_sclk,
    input  wire logic                       i_cs_n,
    input  wire logic                       i_mosi,
    input  wire logic                       i_supply_ok,
    input  wire logic                       i_send,
    input  wire logic [7:0]                 i_tx_byte,
    output logic                            o_miso,
    output logic                            o_miso_oe,
    output logic                            o_request,
    output logic                            o_request_oe,
    output logic                            o_busy,
    output logic                            o_selected,
    output logic                            o_rx_valid,
    output logic [7:0]                      o_rx_byte,
    output logic [smh_pkg::TIME_W-1:0]      o_ready_time_us,
    output logic [smh_pkg::TIME_W-1:0]      o_resume_time_us
);
    import smh_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // the reported time must cover the whole path.
    initial begin
        if (READY_US * 1000 < REQ_TIME_NS + PREP_CYCLES * MCLK_PERIOD_NS + SYNC_NS) begin
            $error("Ready time too short for request, preparation and sampling.");
        end
        if (REQ_CYC >= (1 << CNT_W) || PREP_CYCLES >= (1 << CNT_W) || PREP_CYCLES < 1) begin
            $error("Interval counts do not fit the counter.");
        end
        if (RESUME_US >= (1 << TIME_W) || READY_US >= (1 << TIME_W)) begin
            $error("Reported times do not fit their fields.");
        end
    end

    localparam logic [CNT_W-1:0] REQ_LAST  = CNT_W'(REQ_CYC - 1);
    localparam logic [CNT_W-1:0] PREP_LAST = CNT_W'(PREP_CYCLES - 1);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] cs_meta;
    logic [1:0] sup_meta;
    logic [2:0] tog_meta;
    logic       cs_s;
    logic       sup_s;
    logic       rx_evt;

    smh_link_if lnk ();

    smh_link u_link (
        .i_sclk    (i_sclk),
        .i_reset_n (i_reset_n),
        .i_cs_n    (i_cs_n),
        .i_mosi    (i_mosi),
        .lnk       (lnk)
    );

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_meta  <= 2'h3;
            sup_meta <= 2'h0;
            tog_meta <= 3'h0;
        end else begin
            cs_meta  <= {cs_meta[0], i_cs_n};
            sup_meta <= {sup_meta[0], i_supply_ok};
            tog_meta <= {tog_meta[1:0], lnk.rx_toggle};
        end
    end

    assign cs_s   = cs_meta[1];
    assign sup_s  = sup_meta[1];
    assign rx_evt = tog_meta[2] ^ tog_meta[1];

    // ------------------------------------------------------------------
    // Handshake state machine
    // ------------------------------------------------------------------
    smh_state_t     state;
    smh_state_t     next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic           pend;
    logic           next_pend;
    logic [7:0]     tx_hold;
    logic [7:0]     next_tx_hold;
    logic [7:0]     tx_new;
    logic [7:0]     next_tx_new;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_pend    = pend | i_send;
        next_tx_new  = i_send ? i_tx_byte : tx_new;
        next_tx_hold = tx_hold;
        unique case (state)
            ST_OFF: begin
                if (sup_s) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!cs_s) begin
                    next_state = ST_SEL;
                end else if (pend) begin
                    next_state   = ST_REQ;
                    next_cnt     = '0;
                    next_tx_hold = tx_new;
                end
            end
            ST_REQ: begin
                next_cnt = cnt + CNT_W'(1);
                if (cnt == REQ_LAST) begin
                    next_cnt   = '0;
                    next_state = cs_s ? ST_PREP : ST_SEL;
                end
            end
            ST_PREP: begin
                next_cnt = cnt + CNT_W'(1);
                if (!cs_s) begin
                    next_state = ST_SEL;
                end else if (cnt == PREP_LAST) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!cs_s) begin
                    next_state = ST_SEL;
                end
            end
            ST_SEL: begin
                next_pend = i_send;
                if (cs_s) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
        if (!sup_s) begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state   <= ST_OFF;
            cnt     <= '0;
            pend    <= 1'b0;
            tx_hold <= TX_RESET;
            tx_new  <= TX_RESET;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            pend    <= next_pend;
            tx_hold <= next_tx_hold;
            tx_new  <= next_tx_new;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs, plus the combinational MISO mux
    // ------------------------------------------------------------------
    logic       next_request;
    logic       next_miso_oe;
    logic       next_rx_valid;
    logic [7:0] next_rx_byte;

    always_comb begin
        next_request  = (next_state == ST_REQ);
        next_miso_oe  = sup_s && !cs_s;
        next_rx_valid = rx_evt && sup_s;
        next_rx_byte  = rx_evt ? lnk.rx_byte : o_rx_byte;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_request        <= 1'b0;
            o_request_oe     <= 1'b0;
            o_miso_oe        <= 1'b0;
            o_busy           <= 1'b0;
            o_selected       <= 1'b0;
            o_rx_valid       <= 1'b0;
            o_rx_byte        <= RX_RESET;
            o_ready_time_us  <= TIME_W'(READY_US);
            o_resume_time_us <= TIME_W'(RESUME_US);
        end else begin
            o_request        <= next_request;
            o_request_oe     <= sup_s;
            o_miso_oe        <= next_miso_oe;
            o_busy           <= (next_state != ST_IDLE);
            o_selected       <= (next_state == ST_SEL);
            o_rx_valid       <= next_rx_valid;
            o_rx_byte        <= next_rx_byte;
            o_ready_time_us  <= TIME_W'(READY_US);
            o_resume_time_us <= TIME_W'(RESUME_US);
        end
    end

    // Bit index and held byte are both stable across each falling edge.
    assign o_miso = tx_hold[~lnk.bit_idx];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    logic [CNT_W-1:0] req_len;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_len <= '0;
        end else begin
            req_len <= o_request ? req_len + CNT_W'(1) : '0;
        end
    end

    property p_req_width;
        $fell(o_request) |-> req_len == CNT_W'(REQ_CYC);
    endproperty
    a_req_width: assert property (p_req_width) else $error("Request pulse width wrong.");

    property p_req_min;
        $rose(o_request) |-> o_request [*8];
    endproperty
    a_req_min: assert property (p_req_min) else $error("Request pulse cut short.");

    property p_req_cs_high;
        $rose(o_request) |-> $past(cs_s) && $past(state) == ST_IDLE;
    endproperty
    a_req_cs_high: assert property (p_req_cs_high) else $error("Request with select low.");

    property p_req_exit;
        $rose(o_request) && sup_s |-> ##[50:51] !o_request;
    endproperty
    a_req_exit: assert property (p_req_exit) else $error("Request state not left.");

    property p_both;
        state == ST_REQ && !cs_s && sup_s && cnt < REQ_LAST |=> state == ST_REQ;
    endproperty
    a_both: assert property (p_both) else $error("Pulse dropped on master select.");

    property p_prep;
        $fell(o_request) && cs_s && sup_s |-> state == ST_PREP;
    endproperty
    a_prep: assert property (p_prep) else $error("No preparation after pulse.");

    property p_wait_ready;
        $rose(state == ST_WAIT) |-> $past(cnt) == PREP_LAST;
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("Preparation length wrong.");

    property p_off;
        !$past(sup_s) |-> !o_miso_oe && !o_request_oe && !o_request;
    endproperty
    a_off: assert property (p_off) else $error("Line driven without supply.");

    property p_miso_cs;
        o_miso_oe |-> !$past(cs_s);
    endproperty
    a_miso_cs: assert property (p_miso_cs) else $error("MISO driven while deselected.");

    property p_ready_rep;
        o_ready_time_us == TIME_W'(READY_US) && o_resume_time_us == TIME_W'(RESUME_US);
    endproperty
    a_ready_rep: assert property (p_ready_rep) else $error("Reported time changed.");

    c_slave_req: cover property ($fell(o_request) ##[1:20] state == ST_WAIT);
    c_master_sel: cover property (state == ST_IDLE && !cs_s ##1 state == ST_SEL);
    c_simult: cover property (state == ST_REQ && !cs_s ##[1:60] state == ST_SEL);
    c_rx_byte: cover property (o_rx_valid && o_selected);

endmodule

//--- verification/smh_master_model.sv
// Purpose: Behavioural bus master for the five-signal access handshake.
// Assumes: Serial clock stands low outside frames; mode 0, MSB first.
// Notes:   One byte per access; the wait is taken from the reported ready time.
`timescale 1ns/1ns
module smh_master_model (
    input  wire logic        i_request,
    input  wire logic        i_miso,
    input  wire logic [15:0] i_ready_us,
    output logic             o_cs_n,
    output logic             o_sclk,
    output logic             o_mosi
);
    logic [7:0] send_byte;
    logic [7:0] got_byte;
    int         extra_ns;
    int         n_access;
    bit         busy;

    initial begin
        o_cs_n    = 1'b1;
        o_sclk    = 1'b0;
        o_mosi    = 1'b0;
        send_byte = 8'h00;
        got_byte  = 8'h00;
        extra_ns  = 0;
        n_access  = 0;
        busy      = 1'b0;
    end

    // ------------------------------------------------------------------
    // Access sequence
    // ------------------------------------------------------------------
    task automatic access(input bit from_req);
        int i;
        busy = 1'b1;
        if (!from_req) begin
            o_cs_n = 1'b0;
        end
        #(i_ready_us * 1000 + extra_ns);
        o_cs_n = 1'b0;
        // Select setup covers the slave's two-flop sense path before MISO is enabled.
        #100;
        for (i = 7; i >= 0; i--) begin
            o_mosi = send_byte[i];
            #16;
            got_byte[i] = i_miso;
            o_sclk = 1'b1;
            #16;
            o_sclk = 1'b0;
        end
        #16;
        o_mosi = ~o_mosi;
        o_cs_n = 1'b1;
        n_access++;
        #100;
        busy = 1'b0;
    endtask

    // A request arriving while an access runs is already served by it.
    always @(posedge i_request) begin
        if (!busy) begin
            access(1'b1);
        end
    end
endmodule

//--- verification/spi_mac_handshake_5sig_bench.sv
// Purpose: Self-checking bench for the access handshake slave.
// Assumes: Request line pulled low and MISO pulled high when released.
// Notes:   Slave, master and simultaneous starts, plus a supply drop.
`timescale 1ns/1ns
module spi_mac_handshake_5sig_bench;
    import smh_pkg::*;

    logic              i_mclk;
    logic              i_reset_n;
    logic              i_supply_ok;
    logic              i_send;
    logic [7:0]        i_tx_byte;
    logic              cs_n, sclk, mosi, miso_line, req_line;
    logic              o_miso, o_miso_oe, o_request, o_request_oe;
    logic              o_busy, o_selected, o_rx_valid;
    logic [7:0]        o_rx_byte, rx_seen, last_tx;
    logic [TIME_W-1:0] o_ready_time_us, o_resume_time_us;
    logic [3:0]        cs_hist;
    int                bad_count, n_checks, cycles, high_run, last_width, n_req, n_rx, seed;
    int                sel_seen;

    initial i_mclk = 1'b0;
    always #10 i_mclk = ~i_mclk;

    assign miso_line = o_miso_oe ? o_miso : 1'b1;
    assign req_line  = o_request_oe ? o_request : 1'b0;

    smh_slave DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_mosi(mosi), .i_supply_ok(i_supply_ok), .i_send(i_send), .i_tx_byte(i_tx_byte),
        .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_request(o_request),
        .o_request_oe(o_request_oe), .o_busy(o_busy), .o_selected(o_selected),
        .o_rx_valid(o_rx_valid), .o_rx_byte(o_rx_byte), .o_ready_time_us(o_ready_time_us),
        .o_resume_time_us(o_resume_time_us));

    smh_master_model master (.i_request(req_line), .i_miso(miso_line),
        .i_ready_us(o_ready_time_us), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));

    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic int req_cycles(input int ns);
        return (ns + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    endfunction

    // ------------------------------------------------------------------
    // Monitor: request pulse width, select before request, received bytes
    // ------------------------------------------------------------------
    always @(posedge i_mclk) begin
        cycles++;
        cs_hist <= {cs_hist[2:0], cs_n};
        if (o_rx_valid === 1'b1) begin
            rx_seen <= o_rx_byte;
            n_rx++;
        end
        if (o_selected === 1'b1) begin
            sel_seen = 1;
        end
        if (req_line === 1'b1) begin
            if (high_run == 0) begin
                n_req++;
                chk_val(cs_hist[2], 1'b1);
            end
            high_run++;
        end else if (high_run > 0) begin
            last_width = high_run;
            high_run   = 0;
        end
        if (cycles > 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // Mode 0: slave starts, 1: master starts, 2: both start together.
    task automatic run_access(input logic [7:0] tx, input logic [7:0] rx, input int mode);
        int acc0, req0, rx0, k;
        acc0 = master.n_access;
        req0 = n_req;
        rx0  = n_rx;
        sel_seen = 0;
        master.send_byte = rx;
        master.extra_ns  = $urandom % 400;
        if (mode != 1) begin
            i_tx_byte = tx;
            i_send    = 1'b1;
            last_tx   = tx;
            @(negedge i_mclk);
            i_send = 1'b0;
        end
        if (mode != 0) begin
            fork
                master.access(1'b0);
            join_none
        end
        k = 0;
        while (master.n_access == acc0 && k < 3000) begin
            @(negedge i_mclk);
            k++;
        end
        repeat (10) @(negedge i_mclk);
        chk_cnt(master.n_access, acc0 + 1);
        chk_val(master.got_byte, last_tx);
        chk_val(rx_seen, rx);
        chk_cnt(n_rx - rx0, 1);
        chk_cnt(n_req - req0, (mode == 1) ? 0 : 1);
        if (mode != 1) begin
            chk_cnt(last_width, req_cycles(1000));
        end
        chk_val(o_busy, 1'b0);
        chk_cnt(sel_seen, 1);
        chk_val(o_selected, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        bad_count = 0; n_checks = 0; cycles = 0; high_run = 0; last_width = 0;
        n_req = 0; n_rx = 0; rx_seen = 8'h00; last_tx = 8'h00; cs_hist = 4'hF; sel_seen = 0;
        i_reset_n = 1'b0; i_supply_ok = 1'b1; i_send = 1'b0; i_tx_byte = 8'h00;
        seed = $urandom(58);
        repeat (4) @(negedge i_mclk);
        i_reset_n = 1'b1;
        repeat (6) @(negedge i_mclk);
        chk_val(o_ready_time_us, 16'(READY_TIME_US));
        chk_val(o_resume_time_us, 16'(RESUME_TIME_US));
        chk_cnt(o_ready_time_us * 1000 >= 1000 + PREP_TIME_NS + SYNC_NS, 1);
        chk_val(o_request_oe, 1'b1);
        run_access(8'hA5, 8'h3C, 0);
        run_access(8'h00, 8'hFF, 1);
        run_access(8'hFF, 8'h00, 2);
        repeat (6) run_access(8'($urandom), 8'($urandom), $urandom % 3);
        i_supply_ok = 1'b0;
        repeat (4) @(negedge i_mclk);
        chk_val({o_miso_oe, o_request_oe, o_request}, 3'h0);
        i_supply_ok = 1'b1;
        repeat (6) @(negedge i_mclk);
        chk_val(o_request_oe, 1'b1);
        run_access(8'h81, 8'h7E, 0);
        end_sim();
    end
endmodule
